// ==== core/mmsd_decoder.sv ====
// Memory map decoder and external strobe gating for the CPU
// expansion bus. Assumes the CPU core drives raw active-low strobes and
// address on core_clk; external SRAM/ROM sits on the pins.
//
// Summary of operation
// R1: General RAM decoded at bottom of map
// R2: Location low: code internal, fetch/read merged
// R3: Location high: all fetches go external
// R4: Bulk buffers and control registers in data
// R5: 8-KB variant aliases bulk buffers low
// R6: Software avoids range above aliased buffers
// R7: Iso disable exposes FIFO RAM as data
// R8: Iso disable resets to zero
// R9: No data strobes inside exposed FIFO RAM
// R10: Software never uses iso endpoints when disabled
// R11: Internal code range suppresses fetch strobe
// R12: Internal moves produce no external strobes
// R13: Read/write gated off internal addresses
// R14: Select low on any qualified strobe
// R15: Output enable low on read or fetch
// R16: Select and enable only for external access
// R17: Location high: internal RAM is data only
// R18: Non-multiplexed 16-bit address, 8-bit data
// R19: Read/write strobes share port C pins
// R20: Fetch uses fetch strobe, moves use read/write
// R21: Firmware uses upper buffer addresses
// R22: Strobes high in reset and idle
`timescale 1ns/1ps
`include "mmsd_consts.svh"

module mmsd_decoder #(
    // Nonzero for the 8-KB RAM variant with the low alias
    parameter bit EIGHT_KB_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Pins
    input  wire logic        code_location_select,
    input  wire logic        port_c_mem_expand,
    input  wire logic [7:0]  ext_data_in,
    // CPU core side, same clock domain
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_fetch_n,
    input  wire logic        cpu_rd_n,
    input  wire logic        cpu_wr_n,
    input  wire logic        iso_ctl_wr,
    input  wire logic [7:0]  iso_ctl_wdata,
    // Expansion bus outputs
    output logic [15:0]      ext_addr,
    output logic [7:0]       ext_data_out,
    output logic             ext_data_oe,
    output logic             program_fetch_strobe_n,
    output logic             port_c_bit7,
    output logic             port_c_bit6,
    output logic             chip_select_n,
    output logic             output_enable_n,
    // Internal side
    output logic             int_sel,
    output mmsd_pkg::mmsd_region_t int_region,
    output logic             iso_space_disable,
    output logic [7:0]       cpu_rdata
);

    // Two-stage synchronisers for pin inputs
    logic       loc_meta;   // First stage, read only by loc_sync
    logic       loc_sync;   // Code-location level
    logic       exp_meta;   // First stage, read only by exp_sync
    logic       exp_sync;   // Port C expansion strap
    logic [7:0] din_meta;   // First stage of data bus
    logic [7:0] din_sync;   // Data bus as the core sees it

    // Pins are asynchronous to core_clk, so two flops each
    always_ff @(posedge core_clk)
    begin
        loc_meta <= code_location_select;
        loc_sync <= loc_meta;
        exp_meta <= port_c_mem_expand;
        exp_sync <= exp_meta;
        din_meta <= ext_data_in;
        din_sync <= din_meta;
    end

    // Iso control register, bit 0 disables iso space
    logic [7:0] iso_ctl;
    always_ff @(posedge core_clk)
    begin
        if (srst)
            iso_ctl <= `MMSD_ISO_CTL_RST;            // [R8]
        else if (iso_ctl_wr)
            iso_ctl <= iso_ctl_wdata;
    end
    wire iso_dis = iso_ctl[`MMSD_ISO_DIS_BIT];     // [R7]

    // Region decode of the current address
    mmsd_pkg::mmsd_region_t region;
    logic                   addr_internal;
    mmsd_region_decode u_dec (
        .addr              (cpu_addr),
        .iso_space_disable (iso_dis),
        .alias_enable      (EIGHT_KB_VARIANT),
        .region            (region),
        .is_internal       (addr_internal)
    );

    // Raw strobe activity
    wire fetch_req = !cpu_fetch_n;
    wire rd_req    = !cpu_rd_n;
    wire wr_req    = !cpu_wr_n;

    // Fetch is internal only with location low in general RAM
    wire fetch_int = !loc_sync &&
                     region == mmsd_pkg::MMSD_REG_GEN;  // [R2] [R11]
    // With location high all fetches go out
    wire fetch_ext = fetch_req && !fetch_int;          // [R3] [R20]

    // Data moves stay inside for every internal region
    wire data_int = addr_internal;               // [R1] [R4] [R5] [R17]
    wire rd_ext   = rd_req && !data_int;              // [R12] [R13] [R9]
    wire wr_ext   = wr_req && !data_int;              // [R12] [R13] [R9]

    // Internal select; merged fetch/read when code sits inside
    wire int_rd   = rd_req && data_int;
    wire int_wr   = wr_req && data_int;
    wire int_fch  = fetch_req && fetch_int;            // [R2]
    wire next_int = int_rd || int_wr || int_fch;

    // Combined outputs derived only from qualified strobes
    wire next_cs  = fetch_ext || rd_ext || wr_ext;     // [R14] [R16]
    wire next_oe  = fetch_ext || rd_ext;               // [R15] [R16]

    // Registered expansion outputs; all strobes idle high in reset
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            program_fetch_strobe_n <= 1'b1;            // [R22]
            port_c_bit7            <= 1'b1;
            port_c_bit6            <= 1'b1;
            chip_select_n          <= 1'b1;
            output_enable_n        <= 1'b1;
            ext_addr               <= 16'h0000;
            ext_data_out           <= 8'h00;
            ext_data_oe            <= 1'b0;
        end
        else
        begin
            program_fetch_strobe_n <= !fetch_ext;      // [R20]
            // Read/write share port C pins when expanded
            port_c_bit7  <= exp_sync ? !rd_ext : 1'b1; // [R19]
            port_c_bit6  <= exp_sync ? !wr_ext : 1'b1; // [R19]
            chip_select_n   <= !next_cs;
            output_enable_n <= !next_oe;
            ext_addr        <= cpu_addr;               // [R18]
            ext_data_out    <= cpu_wdata;              // [R18]
            ext_data_oe     <= wr_ext && exp_sync;
        end
    end

    // Internal-side registered outputs
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            int_sel           <= 1'b0;
            int_region        <= mmsd_pkg::MMSD_REG_NONE;
            iso_space_disable <= 1'b0;
            cpu_rdata         <= 8'h00;
        end
        else
        begin
            int_sel           <= next_int;
            int_region        <= region;
            iso_space_disable <= iso_dis;
            cpu_rdata         <= din_sync;
        end
    end

    // Assertion helpers: previous-cycle qualified terms
    default clocking mmsd_cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence iso_data_acc;
        iso_dis && (rd_req || wr_req) && !fetch_req &&
        cpu_addr >= `MMSD_ISO_LO && cpu_addr <= `MMSD_ISO_HI;
    endsequence

    iso_quiet_a: assert property (iso_data_acc |=> // [R9]
        port_c_bit7 && port_c_bit6 && chip_select_n && output_enable_n)
        else $error("strobe asserted in exposed iso RAM");

    fetch_inh_a: assert property ( // [R11]
        (fetch_req && !loc_sync && cpu_addr <= `MMSD_GEN_RAM_HI)
        |=> program_fetch_strobe_n)
        else $error("fetch strobe in internal code range");

    fetch_ext_a: assert property ( // [R3]
        (fetch_req && loc_sync) |=> !program_fetch_strobe_n)
        else $error("fetch not external with location high");

    bulk_quiet_a: assert property ( // [R12]
        (!fetch_req && (rd_req || wr_req) && cpu_addr >= `MMSD_BULK_LO &&
         cpu_addr <= `MMSD_CREG_HI)
        |=> chip_select_n && port_c_bit7 && port_c_bit6)
        else $error("external strobe for internal register space");

    cs_track_a: assert property ( // [R14]
        (!program_fetch_strobe_n || !port_c_bit7 || !port_c_bit6)
        |-> !chip_select_n)
        else $error("select high during qualified strobe");

    oe_write_a: assert property ( // [R15]
        (wr_ext && !rd_ext && !fetch_ext) |=> output_enable_n)
        else $error("output enable asserted for write");

    cs_ext_a: assert property ( // [R16]
        !chip_select_n |-> !$past(addr_internal) || $past(fetch_ext))
        else $error("select asserted for internal access");

    reset_idle_a: assert property ( // [R22]
        @(posedge core_clk) disable iff (1'b0)
        $past(srst) |-> program_fetch_strobe_n && chip_select_n &&
        output_enable_n && port_c_bit7 && port_c_bit6)
        else $error("strobe active after reset");

    iso_default_a: assert property ( // [R8]
        @(posedge core_clk) disable iff (1'b0)
        ($past(srst) && srst) |-> !iso_dis)
        else $error("iso disable not cleared by reset");

    // Fetch alone, location low, inside general RAM
    sequence code_fetch_int;
        fetch_req && !rd_req && !wr_req && !loc_sync &&
        cpu_addr <= `MMSD_GEN_RAM_HI;
    endsequence

    // Fetch alone with the location pin high
    sequence code_fetch_ext;
        fetch_req && !rd_req && !wr_req && loc_sync;
    endsequence

    // Data move alone to an address outside the chip
    sequence data_move_ext;
        (rd_req || wr_req) && !fetch_req && !addr_internal;
    endsequence

    merge_int_a: assert property ( // [R2]
        code_fetch_int |=> int_sel &&
        int_region == mmsd_pkg::MMSD_REG_GEN)
        else $error("internal fetch not served by general RAM");

    fetch_data_a: assert property ( // [R17]
        code_fetch_ext |=> !int_sel && !chip_select_n)
        else $error("fetch served inside with location high");

    move_ext_a: assert property ( // [R16]
        data_move_ext |=> !chip_select_n && !int_sel)
        else $error("external data move not selected outside");

    oe_read_a: assert property ( // [R15]
        (rd_req && !addr_internal) |=> !output_enable_n)
        else $error("output enable idle for external read");

    rd_gate_a: assert property ( // [R13]
        (rd_req && addr_internal) |=> port_c_bit7)
        else $error("read strobe for internal address");

    wr_gate_a: assert property ( // [R13]
        (wr_req && addr_internal) |=> port_c_bit6 && !ext_data_oe)
        else $error("write strobe for internal address");

    port_free_a: assert property ( // [R19]
        !exp_sync |=> port_c_bit7 && port_c_bit6)
        else $error("port C strobe while not expanded");

    // Alias exists only in the larger RAM variant
    alias_map_a: assert property ( // [R5]
        (EIGHT_KB_VARIANT && cpu_addr >= `MMSD_ALIAS_LO &&
         cpu_addr <= `MMSD_ALIAS_RSV_HI)
        |=> int_region == mmsd_pkg::MMSD_REG_ALIAS)
        else $error("bulk alias not decoded low");

    iso_map_a: assert property ( // [R7]
        (iso_dis && cpu_addr >= `MMSD_ISO_LO && cpu_addr <= `MMSD_ISO_HI)
        |=> int_region == mmsd_pkg::MMSD_REG_ISO && iso_space_disable)
        else $error("iso RAM not decoded as data");

    addr_pass_a: assert property ( // [R18]
        1'b1 |=> ext_addr == $past(cpu_addr))
        else $error("address bus does not follow core");

    // No request at all must leave every strobe parked high
    idle_high_a: assert property ( // [R22]
        (!fetch_req && !rd_req && !wr_req) |=> program_fetch_strobe_n &&
        port_c_bit7 && port_c_bit6 && chip_select_n && output_enable_n)
        else $error("strobe active with no access");

    buf_reach_a: assert property ( // [R4]
        ((rd_req || wr_req) && cpu_addr >= `MMSD_BULK_LO &&
         cpu_addr <= `MMSD_CREG_HI) |=> int_sel)
        else $error("buffer or register space not reached");

endmodule

// ==== core/mmsd_consts.svh ====
// Address map constants and iso control defaults for the memory map strobe decoder.
// Assumes a 16-bit CPU address space; included by bare name.
`ifndef MMSD_CONSTS_SVH
`define MMSD_CONSTS_SVH

// General code/data RAM
`define MMSD_GEN_RAM_LO    16'h0000
`define MMSD_GEN_RAM_HI    16'h1b3f
// Aliased bulk buffer window (8-KB variant)
`define MMSD_ALIAS_LO      16'h1b40
`define MMSD_ALIAS_HI      16'h1f3f
// Alias of control registers, reserved for software
`define MMSD_ALIAS_RSV_LO  16'h1f40
`define MMSD_ALIAS_RSV_HI  16'h1fff
// Isochronous FIFO RAM exposed when iso space is disabled
`define MMSD_ISO_LO        16'h2000
`define MMSD_ISO_HI        16'h27ff
// Bulk endpoint buffers and control registers
`define MMSD_BULK_LO       16'h7b40
`define MMSD_BULK_HI       16'h7f3f
`define MMSD_CREG_LO       16'h7f40
`define MMSD_CREG_HI       16'h7fff
// Iso control register bit position and reset value
`define MMSD_ISO_DIS_BIT   0
`define MMSD_ISO_CTL_RST   8'h00

`endif

// ==== core/mmsd_pkg.sv ====
// Types shared by the memory map strobe decoder files.
// Assumes the constants header is compiled alongside.
package mmsd_pkg;

    // Internal region that an access decodes to
    typedef enum logic [2:0] {
        MMSD_REG_NONE  = 3'h0,
        MMSD_REG_GEN   = 3'h1,
        MMSD_REG_ALIAS = 3'h3,
        MMSD_REG_ISO   = 3'h2,
        MMSD_REG_BULK  = 3'h6,
        MMSD_REG_CREG  = 3'h7
    } mmsd_region_t;

endpackage

// ==== core/mmsd_region_decode.sv ====
// Combinational address-to-region decode for the strobe decoder.
// Assumes a 16-bit address; pure logic, no clock.
`timescale 1ns/1ps
`include "mmsd_consts.svh"

module mmsd_region_decode (
    // Address and mode
    input  wire logic [15:0]          addr,
    input  wire logic                 iso_space_disable,
    input  wire logic                 alias_enable,
    // Decode result
    output mmsd_pkg::mmsd_region_t    region,
    output logic                      is_internal
);

    // Region hits
    wire hit_gen   = addr <= `MMSD_GEN_RAM_HI;
    wire hit_alias = alias_enable && addr >= `MMSD_ALIAS_LO &&
                     addr <= `MMSD_ALIAS_RSV_HI;
    wire hit_iso   = iso_space_disable && addr >= `MMSD_ISO_LO &&
                     addr <= `MMSD_ISO_HI;
    wire hit_bulk  = addr >= `MMSD_BULK_LO && addr <= `MMSD_BULK_HI;
    wire hit_creg  = addr >= `MMSD_CREG_LO && addr <= `MMSD_CREG_HI;

    // Priority encode; regions never overlap
    assign region = hit_gen   ? mmsd_pkg::MMSD_REG_GEN   :
                    hit_alias ? mmsd_pkg::MMSD_REG_ALIAS :
                    hit_iso   ? mmsd_pkg::MMSD_REG_ISO   :
                    hit_bulk  ? mmsd_pkg::MMSD_REG_BULK  :
                    hit_creg  ? mmsd_pkg::MMSD_REG_CREG  :
                                mmsd_pkg::MMSD_REG_NONE;
    assign is_internal = region != mmsd_pkg::MMSD_REG_NONE;

endmodule

// ==== test/mmsd_ext_mem.sv ====
// External byte memory on the expansion bus, behind the decoder.
// Assumes strobes come straight from the decoder pins; no wait states.
`timescale 1ns/1ps

module mmsd_ext_mem (
    // Clock
    input  wire logic        core_clk,
    // Expansion bus from the decoder
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_data_out,
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        port_c_bit6,
    // Data back to the decoder
    output logic [7:0]       ext_data_in
);
    logic [7:0] mem [0:255];      // Low address byte only, to stay small
    logic [7:0] last = 8'h00;     // Last value put on the bus
    logic       drive;            // Memory is driving the data bus

    // Drives only while selected and output-enabled
    assign drive = !chip_select_n && !output_enable_n;
    // Released bus shows a toggling value so stale data never matches
    assign ext_data_in = drive ? mem[ext_addr[7:0]] : ~last;

    // Write on select plus write strobe; track bus value
    always @(posedge core_clk)
    begin
        if (!chip_select_n && !port_c_bit6)
            mem[ext_addr[7:0]] <= ext_data_out;
        last <= drive ? ext_data_in : ~last;
    end
endmodule

// ==== test/tb_memory_map_strobe_decoder.sv ====
// Bench for the strobe decoder: sweeps the map in three pin/iso modes of the 8-KB variant.
// Assumes the external memory model file is compiled first.
`timescale 1ns/1ps

module tb_memory_map_strobe_decoder;
    // Design pins, named as the ports
    logic        core_clk, srst, code_location_select, port_c_mem_expand;
    logic [7:0]  ext_data_in, cpu_wdata, iso_ctl_wdata, ext_data_out;
    logic [7:0]  cpu_rdata;
    logic [15:0] cpu_addr, ext_addr;
    logic        cpu_fetch_n, cpu_rd_n, cpu_wr_n, iso_ctl_wr, ext_data_oe;
    logic        program_fetch_strobe_n, port_c_bit7, port_c_bit6;
    logic        chip_select_n, output_enable_n, int_sel, iso_space_disable;
    mmsd_pkg::mmsd_region_t int_region; // Region code latched by the core
    logic        iso_set;         // Iso bit last written
    int          num_errors, cmp_count;
    // Region edges; 1f40-1fff probed for quiet strobes, no data kept
    logic [15:0] addr_tab [15] = '{16'h0000, 16'h1b3f, 16'h1b40, 16'h1f3f,
        16'h1f40, 16'h1fff, 16'h2000, 16'h27ff, 16'h2800, 16'h7b3f,
        16'h7b40, 16'h7f40, 16'h7fff, 16'h8000, 16'hffff};

    mmsd_decoder dut (
        .core_clk, .srst, .code_location_select, .port_c_mem_expand,
        .ext_data_in, .cpu_addr, .cpu_wdata, .cpu_fetch_n, .cpu_rd_n,
        .cpu_wr_n, .iso_ctl_wr, .iso_ctl_wdata, .ext_addr, .ext_data_out,
        .ext_data_oe, .program_fetch_strobe_n, .port_c_bit7, .port_c_bit6,
        .chip_select_n, .output_enable_n, .int_sel, .int_region,
        .iso_space_disable, .cpu_rdata);

    mmsd_ext_mem mem (.core_clk, .ext_addr, .ext_data_out, .chip_select_n,
        .output_enable_n, .port_c_bit6, .ext_data_in);

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Address implemented inside the chip (8-KB variant)
    function automatic logic internal(input logic [15:0] a);
        return a <= 16'h1fff || (a >= 16'h7b40 && a <= 16'h7fff) ||
            (iso_set && a >= 16'h2000 && a <= 16'h27ff);
    endfunction

    // Region code the map gives an address (8-KB variant)
    function automatic mmsd_pkg::mmsd_region_t region_of(
        input logic [15:0] a);
        if (a <= 16'h1b3f)
            return mmsd_pkg::MMSD_REG_GEN;
        else if (a <= 16'h1fff)
            return mmsd_pkg::MMSD_REG_ALIAS;
        else if (iso_set && a >= 16'h2000 && a <= 16'h27ff)
            return mmsd_pkg::MMSD_REG_ISO;
        else if (a >= 16'h7b40 && a <= 16'h7f3f)
            return mmsd_pkg::MMSD_REG_BULK;
        else if (a >= 16'h7f40 && a <= 16'h7fff)
            return mmsd_pkg::MMSD_REG_CREG;
        else
            return mmsd_pkg::MMSD_REG_NONE;
    endfunction

    // One access: kind 0 fetch, 1 read, 2 write; held for hold cycles
    task automatic access(input logic [1:0] k, input logic [15:0] a,
                          input int hold);
        logic ext;  // Access leaves the chip
        logic pce;  // Port C strobes carry it
        ext = (k == 2'h0) ? !(!code_location_select && a <= 16'h1b3f)
                          : !internal(a);
        pce = ext && port_c_mem_expand;
        {cpu_fetch_n, cpu_rd_n, cpu_wr_n} = ~(3'h4 >> k);
        cpu_addr = a;
        cpu_wdata = a[7:0] ^ 8'h3c;
        repeat (hold) @(negedge core_clk);
        check(program_fetch_strobe_n, !(k == 2'h0 && ext));
        check(port_c_bit7, !(k == 2'h1 && pce));
        check(port_c_bit6, !(k == 2'h2 && pce));
        check(chip_select_n, !ext);
        check(output_enable_n, !(ext && k != 2'h2));
        check(ext_addr, a);
        check(int_sel, !ext);
        check(int_region, region_of(a));
        if (k == 2'h2)
            check({ext_data_oe, ext_data_out}, {pce, cpu_wdata});
    endtask

    // Strobes released, all pins back high
    task automatic idle();
        {cpu_fetch_n, cpu_rd_n, cpu_wr_n} = 3'h7;
        repeat (2) @(negedge core_clk);
        check({program_fetch_strobe_n, port_c_bit7, port_c_bit6,
               chip_select_n, output_enable_n}, 5'h1f);
    endtask

    // Pins and iso bit; waits out the pin synchronisers
    task automatic set_mode(input logic l, input logic e, input logic i);
        code_location_select = l;
        port_c_mem_expand = e;
        iso_ctl_wdata = {7'h00, i};
        iso_ctl_wr = 1'b1; // no iso traffic is ever started
        iso_set = i;
        @(negedge core_clk);
        iso_ctl_wr = 1'b0;
        repeat (4) @(negedge core_clk);
        check(iso_space_disable, i);
    endtask

    // Every kind at each address in addr_tab, back to back
    task automatic test_sweep(input logic l, input logic e, input logic i);
        set_mode(l, e, i);
        for (int k = 0; k < 3; k++)
            foreach (addr_tab[n])
                access(k[1:0], addr_tab[n], 1);
        idle();
    endtask

    // Write then read back through the synchronised data path
    task automatic test_rdata();
        set_mode(1'b0, 1'b1, 1'b0);
        access(2'h2, 16'h7b40, 1);
        access(2'h2, 16'h8010, 1);
        access(2'h1, 16'h8010, 5);
        check(cpu_rdata, 8'h2c);
        idle();
    endtask

    // Reset in mid-run with iso space disabled and a fetch pending
    task automatic test_reset();
        set_mode(1'b1, 1'b1, 1'b1);
        {cpu_fetch_n, cpu_rd_n, cpu_wr_n} = 3'h3;
        cpu_addr = 16'h9000;
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        check({program_fetch_strobe_n, port_c_bit7, port_c_bit6,
               chip_select_n, output_enable_n, iso_space_disable,
               int_sel}, 7'h7c);
        srst = 1'b0;
        iso_set = 1'b0;
        // Iso bit cleared by reset, so this read goes out
        access(2'h1, 16'h2000, 1);
        idle();
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence; all waits are fixed counts
    initial
    begin
        {srst, code_location_select, port_c_mem_expand, iso_ctl_wr} = 4'h9;
        {cpu_fetch_n, cpu_rd_n, cpu_wr_n} = 3'h5;
        {cpu_addr, cpu_wdata, iso_ctl_wdata} = {16'h8000, 16'h0000};
        num_errors = 0;
        cmp_count = 0;
        iso_set = 1'b0;
        repeat (10) @(negedge core_clk);
        // Raw read asserted, yet pins must stay high in reset
        check({program_fetch_strobe_n, port_c_bit7, port_c_bit6,
               chip_select_n, output_enable_n, iso_space_disable},
              6'h3e);
        srst = 1'b0;
        test_sweep(1'b0, 1'b1, 1'b0);
        test_sweep(1'b1, 1'b1, 1'b1);
        test_sweep(1'b0, 1'b0, 1'b1);
        test_rdata();
        test_reset();
        print_verdict();
    end
endmodule
